// ==== include/rcd_pkg.sv ====
// Package of constants and types for the remote control input decoder.
package rcd_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  // Least hold time of a momentary remote command, in milliseconds.
  localparam int unsigned QUAL_MIN_MS = 50;
  localparam int unsigned QUAL_CYCLES = (CLK_HZ / 1000) * QUAL_MIN_MS;
  // Interval between two power steps while ramping, in microseconds.
  localparam int unsigned RAMP_STEP_US = 100;
  localparam int unsigned RAMP_CYCLES = (CLK_HZ / 1_000_000) * RAMP_STEP_US;

  // ************************************************************
  // Remote input positions in the qualified input vector
  // ************************************************************
  localparam int unsigned N_IN = 13;
  localparam int unsigned IN_OFF = 6;
  localparam int unsigned IN_RAISE = 7;
  localparam int unsigned IN_LOWER = 8;
  localparam int unsigned IN_PRIMARY = 9;
  localparam int unsigned IN_BACKUP = 10;
  localparam int unsigned IN_MUTE = 11;
  localparam int unsigned IN_FAULT = 12;

  // ************************************************************
  // Register map, byte addresses and reset values
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PRESET1 = 8'h04;
  localparam logic [7:0] ADDR_PRESET6 = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_LEVEL = 8'h20;
  localparam logic CTRL_RESET = 1'h0;
  localparam logic [15:0] PRESET_RESET = 16'h0000;
  localparam logic [15:0] LEVEL_MAX = 16'hFFFF;
  // Status register field positions.
  localparam int unsigned ST_RF_ON = 16;
  localparam int unsigned ST_MUTE = 17;
  localparam int unsigned ST_BACKUP = 18;
  localparam int unsigned ST_SEL = 20;
  localparam int unsigned ST_FSM = 24;

  // ************************************************************
  // Power control states
  // ************************************************************
  typedef enum logic [3:0] {
    RCD_IDLE = 4'h1,
    RCD_RAMP = 4'h2,
    RCD_RAISE = 4'h4,
    RCD_LOWER = 4'h8
  } rcd_fsm_t;

endpackage : rcd_pkg

// ==== design/rcd_qualifier.sv ====
// Synchroniser and minimum-hold qualifier for one remote contact input.
`timescale 1ns/10ps
module rcd_qualifier #(
  parameter int unsigned MIN_CYCLES = rcd_pkg::QUAL_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic raw_i,
  input wire logic polarity_i,
  output logic level_o
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [31:0] cnt;
    logic level;
  } rcd_qual_state_t;

  rcd_qual_state_t s;
  rcd_qual_state_t next_s;

  // Polarity turns the pin into an active-high request, then the level
  // must stand unbroken for MIN_CYCLES before it counts. A single drop
  // restarts the count, so contact bounce never qualifies.
  always_comb begin
    next_s = s;
    next_s.sync1 = polarity_i ? raw_i : ~raw_i;
    next_s.sync2 = s.sync1;
    if (!s.sync2) begin
      next_s.cnt = 32'h0;
      next_s.level = 1'b0;
    end else if (s.cnt == MIN_CYCLES - 1) begin
      next_s.level = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 32'h1;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level_o = s.level;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_rise_after_min: assert property (
    $rose(level_o) |-> s.cnt == MIN_CYCLES - 1 && $past(s.sync2))
    else $error("qualified level rose before the minimum hold time");

  a_drop_on_idle: assert property (
    !s.sync2 |=> !level_o)
    else $error("qualified level stayed after the input went idle");

  a_polarity_high: assert property (
    (polarity_i && !raw_i) [*3] |=> !level_o)
    else $error("low pin counted as active with high polarity");

  a_polarity_low: assert property (
    (!polarity_i && raw_i) [*3] |=> !level_o)
    else $error("high pin counted as active with ground polarity");

endmodule : rcd_qualifier

// ==== design/rcd_top.sv ====
// Remote control discrete input decoder with its AHB-Lite register slave.
`timescale 1ns/10ps
module rcd_top #(
  parameter int unsigned QUAL_CYCLES = rcd_pkg::QUAL_CYCLES,
  parameter int unsigned RAMP_CYCLES = rcd_pkg::RAMP_CYCLES
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic polarity_strap_i,
  input wire logic preset_one_select_i,
  input wire logic preset_two_select_i,
  input wire logic preset_three_select_i,
  input wire logic preset_four_select_i,
  input wire logic preset_five_select_i,
  input wire logic preset_six_select_i,
  input wire logic off_request_i,
  input wire logic power_up_request_i,
  input wire logic power_down_request_i,
  input wire logic primary_source_select_i,
  input wire logic backup_source_select_i,
  input wire logic mute_request_i,
  input wire logic fault_reset_request_i,
  input wire logic exciter_analog_only_in_i,
  input wire logic exciter_digital_on_in_i,
  input wire logic exciter_digital_off_in_i,
  input wire logic exciter_halt_in_i,
  output logic rf_on_o,
  output logic [15:0] power_level_o,
  output logic mute_o,
  output logic audio_backup_o,
  output logic fault_clear_o,
  output logic at_preset_three_out_o,
  output logic at_preset_four_out_o,
  output logic at_preset_five_out_o,
  output logic at_preset_six_out_o
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic remote_en;
    logic [5:0][15:0] preset;
    logic [15:0] level;
    logic [15:0] target;
    logic [2:0] sel;
    logic rf_on;
    logic mute;
    logic backup;
    logic fault_clr;
    rcd_pkg::rcd_fsm_t fsm;
    logic [rcd_pkg::N_IN-1:0] q_prev;
    logic [31:0] tick_cnt;
    logic tick;
    logic [3:0] at_preset;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } rcd_top_state_t;

  rcd_top_state_t s;
  rcd_top_state_t next_s;
  logic [rcd_pkg::N_IN-1:0] raw;
  logic [rcd_pkg::N_IN-1:0] q;
  logic [rcd_pkg::N_IN-1:0] cmd;
  logic addr_take;

  // ************************************************************
  // Input qualification
  // ************************************************************
  // The exciter option pins are deliberately left out of this vector.
  assign raw = {fault_reset_request_i, mute_request_i,
                backup_source_select_i, primary_source_select_i,
                power_down_request_i, power_up_request_i, off_request_i,
                preset_six_select_i, preset_five_select_i,
                preset_four_select_i, preset_three_select_i,
                preset_two_select_i, preset_one_select_i};

  // One qualifier per remote input; all share the polarity strap.
  for (genvar gi = 0; gi < rcd_pkg::N_IN; gi++) begin : g_qual
    rcd_qualifier #(
      .MIN_CYCLES(QUAL_CYCLES)
    ) u_qual (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .raw_i(raw[gi]),
      .polarity_i(polarity_strap_i),
      .level_o(q[gi])
    );
  end

  // Commands fire on the qualified rising edge only, and only with remote
  // control enabled; holding a pin never repeats the action.
  assign cmd = q & ~s.q_prev & {rcd_pkg::N_IN{s.remote_en}};

  // ************************************************************
  // Register read decode
  // ************************************************************
  function automatic logic [31:0] read_reg(input rcd_top_state_t st,
                                           input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0;
    if (a == rcd_pkg::ADDR_CTRL) begin
      d[0] = st.remote_en;
    end else if (a >= rcd_pkg::ADDR_PRESET1 &&
                 a <= rcd_pkg::ADDR_PRESET6) begin
      d[15:0] = st.preset[3'((a - rcd_pkg::ADDR_PRESET1) >> 2)];
    end else if (a == rcd_pkg::ADDR_STATUS) begin
      d[rcd_pkg::N_IN-1:0] = st.q_prev;
      d[rcd_pkg::ST_RF_ON] = st.rf_on;
      d[rcd_pkg::ST_MUTE] = st.mute;
      d[rcd_pkg::ST_BACKUP] = st.backup;
      d[rcd_pkg::ST_SEL +: 3] = st.sel;
      d[rcd_pkg::ST_FSM +: 4] = st.fsm;
    end else if (a == rcd_pkg::ADDR_LEVEL) begin
      d[15:0] = st.level;
    end
    return d;
  endfunction : read_reg

  assign addr_take = hsel_i && htrans_i[1] && hready_i;

  // ************************************************************
  // Next state
  // ************************************************************
  // Bus, step divider, command decode and power control in one pass.
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    next_s.fault_clr = 1'b0;
    next_s.q_prev = q;
    next_s.wr_pend = 1'b0;

    // Step divider: one enable pulse every RAMP_CYCLES clocks.
    if (s.tick_cnt == RAMP_CYCLES - 1) begin
      next_s.tick_cnt = 32'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 32'h1;
    end

    // Write data phase: the address was latched one edge earlier.
    if (s.wr_pend) begin
      if (s.wr_addr == rcd_pkg::ADDR_CTRL) begin
        next_s.remote_en = hwdata_i[0];
      end else if (s.wr_addr >= rcd_pkg::ADDR_PRESET1 &&
                   s.wr_addr <= rcd_pkg::ADDR_PRESET6) begin
        next_s.preset[3'((s.wr_addr - rcd_pkg::ADDR_PRESET1) >> 2)] =
          hwdata_i[15:0];
      end
    end

    // Address phase. Read data are sampled here so the data phase
    // needs no wait state; unmapped words read as zero.
    if (addr_take) begin
      if (hwrite_i && hsize_i == 3'h2) begin
        next_s.wr_pend = 1'b1;
        next_s.wr_addr = haddr_i[7:0] & 8'hFC;
      end else if (!hwrite_i) begin
        next_s.rdata = read_reg(s, haddr_i[7:0] & 8'hFC);
      end
    end

    // Mute follows the qualified level with no enable gating.
    next_s.mute = q[rcd_pkg::IN_MUTE];

    // Audio source select.
    if (cmd[rcd_pkg::IN_PRIMARY]) begin
      next_s.backup = 1'b0;
    end
    if (cmd[rcd_pkg::IN_BACKUP]) begin
      next_s.backup = 1'b1;
    end

    // Fault reset is a one-cycle pulse to the fault latches.
    if (cmd[rcd_pkg::IN_FAULT]) begin
      next_s.fault_clr = 1'b1;
    end

    // Power state machine, stepping one unit per divider pulse.
    case (s.fsm)
      rcd_pkg::RCD_IDLE: begin
        next_s.fsm = rcd_pkg::RCD_IDLE;
      end
      rcd_pkg::RCD_RAMP: begin
        if (s.level == s.target) begin
          next_s.fsm = rcd_pkg::RCD_IDLE;
        end else if (s.tick) begin
          next_s.level = (s.level < s.target) ? s.level + 16'h1
                                              : s.level - 16'h1;
        end
      end
      rcd_pkg::RCD_RAISE: begin
        if (!q[rcd_pkg::IN_RAISE] || !s.remote_en) begin
          next_s.fsm = rcd_pkg::RCD_IDLE;
        end else if (s.tick && s.level != rcd_pkg::LEVEL_MAX) begin
          next_s.level = s.level + 16'h1;
        end
      end
      rcd_pkg::RCD_LOWER: begin
        if (!q[rcd_pkg::IN_LOWER] || !s.remote_en) begin
          next_s.fsm = rcd_pkg::RCD_IDLE;
        end else if (s.tick && s.level != 16'h0) begin
          next_s.level = s.level - 16'h1;
        end
      end
      default: begin
        next_s.fsm = rcd_pkg::RCD_IDLE;
      end
    endcase

    // Raise and lower leave the stored preset, so no preset is reported.
    if (cmd[rcd_pkg::IN_RAISE]) begin
      next_s.fsm = rcd_pkg::RCD_RAISE;
      next_s.sel = 3'h0;
    end
    if (cmd[rcd_pkg::IN_LOWER]) begin
      next_s.fsm = rcd_pkg::RCD_LOWER;
      next_s.sel = 3'h0;
    end

    // A preset select turns the carrier on and ramps to the stored value.
    // The highest numbered of simultaneous selects wins.
    for (int i = 0; i < 6; i++) begin
      if (cmd[i]) begin
        next_s.target = s.preset[i];
        next_s.sel = 3'(i + 1);
        next_s.rf_on = 1'b1;
        next_s.fsm = rcd_pkg::RCD_RAMP;
      end
    end

    // Off outranks any preset select, raise or lower command taken in the same cycle.
    if (cmd[rcd_pkg::IN_OFF]) begin
      next_s.rf_on = 1'b0;
      next_s.sel = 3'h0;
      next_s.fsm = rcd_pkg::RCD_IDLE;
    end

    // Preset status: on, settled, selected and at the stored value.
    for (int k = 0; k < 4; k++) begin
      next_s.at_preset[k] = s.rf_on && s.fsm == rcd_pkg::RCD_IDLE &&
                            s.sel == 3'(k + 3) &&
                            s.level == s.preset[k + 2];
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Everything resets together; the strap is never sampled at reset
  // because it is read live by each qualifier.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s <= '0;
      s.remote_en <= rcd_pkg::CTRL_RESET;
      s.preset <= {6{rcd_pkg::PRESET_RESET}};
      s.fsm <= rcd_pkg::RCD_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // The slave never stretches a transfer and never signals an error.
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = s.rdata;
  assign rf_on_o = s.rf_on;
  assign power_level_o = s.level;
  assign mute_o = s.mute;
  assign audio_backup_o = s.backup;
  assign fault_clear_o = s.fault_clr;
  assign at_preset_three_out_o = s.at_preset[0];
  assign at_preset_four_out_o = s.at_preset[1];
  assign at_preset_five_out_o = s.at_preset[2];
  assign at_preset_six_out_o = s.at_preset[3];

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_preset_target: assert property (
    cmd[3] && !cmd[4] && !cmd[5] && !cmd[rcd_pkg::IN_OFF] |=>
      s.target == $past(s.preset[3]) && s.fsm == rcd_pkg::RCD_RAMP
      && rf_on_o)
    else $error("preset four select did not start a ramp to its value");

  a_enable_gates: assert property (
    !s.remote_en |=> $stable(audio_backup_o) && !fault_clear_o)
    else $error("remote command acted while remote control disabled");

  a_off_stops: assert property (
    cmd[rcd_pkg::IN_OFF] |=> !rf_on_o && s.fsm == rcd_pkg::RCD_IDLE)
    else $error("remote off did not turn the transmitter off");

  a_raise_steps: assert property (
    s.fsm == rcd_pkg::RCD_RAISE && q[rcd_pkg::IN_RAISE] && s.remote_en
    && s.tick && s.level != rcd_pkg::LEVEL_MAX && cmd == '0 |=>
      power_level_o == $past(power_level_o) + 16'h1)
    else $error("held raise did not increase the power level");

  a_lower_ends: assert property (
    s.fsm == rcd_pkg::RCD_LOWER && !q[rcd_pkg::IN_LOWER] && cmd == '0 |=>
      s.fsm == rcd_pkg::RCD_IDLE ##1 $stable(power_level_o))
    else $error("lower kept running after its input went idle");

  a_primary_sel: assert property (
    cmd[rcd_pkg::IN_PRIMARY] && !cmd[rcd_pkg::IN_BACKUP] |=>
      !audio_backup_o)
    else $error("primary select did not pick the primary source");

  a_backup_sel: assert property (
    cmd[rcd_pkg::IN_BACKUP] |=> audio_backup_o)
    else $error("backup select did not pick the backup source");

  a_mute_level: assert property (
    q[rcd_pkg::IN_MUTE] != mute_o |=> mute_o == $past(q[rcd_pkg::IN_MUTE]))
    else $error("mute output did not follow the mute input");

  a_fault_pulse: assert property (
    cmd[rcd_pkg::IN_FAULT] |=> fault_clear_o ##1 !fault_clear_o)
    else $error("fault reset was not a single clear pulse");

  a_status_true: assert property (
    at_preset_six_out_o |-> $past(rf_on_o) && $past(s.sel) == 3'h6 &&
      $past(power_level_o) == $past(s.preset[5]))
    else $error("preset six status high away from preset six");

endmodule : rcd_top

// ==== test/rcd_remote_unit.sv ====
// Model of the remote control unit that drives the contact inputs.
`timescale 1ns/10ps
module rcd_remote_unit (
  input wire logic clk_i,
  input wire logic polarity_i,
  input wire logic [12:0] press_i,
  output logic [12:0] pin_o,
  output logic [3:0] exciter_o
);
  // ************************************************************
  // Contact drive
  // ************************************************************
  logic [3:0] toggle = 4'h5;

  // A pressed contact shows the active level that the strap selects.
  always_comb begin
    pin_o = polarity_i ? press_i : ~press_i;
  end

  // The option lines toggle every cycle, so any use of them would show.
  always_ff @(posedge clk_i) begin
    toggle <= ~toggle;
  end
  assign exciter_o = toggle;
endmodule : rcd_remote_unit

// ==== test/testbench.sv ====
// Self-checking testbench for the remote control input decoder.
`timescale 1ns/10ps
module testbench;
  // ************************************************************
  // Signals
  // ************************************************************
  localparam int QUAL = 8;
  localparam int RAMP = 4;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic strap = 1'b1;
  logic [12:0] press = 13'h0;
  logic [12:0] pin;
  logic [3:0] exc;
  logic [31:0] hrdata;
  logic hready, hresp, rf_on, mute, backup, fclr;
  logic [15:0] level;
  logic [3:0] at_pre;
  int failures = 0;
  int tests_run = 0;
  int pulses = 0;
  logic [31:0] rd;
  logic [15:0] lvl;

  rcd_remote_unit u_remote (.clk_i(clk_i), .polarity_i(strap),
    .press_i(press), .pin_o(pin), .exciter_o(exc));

  rcd_top #(.QUAL_CYCLES(QUAL), .RAMP_CYCLES(RAMP)) u_dut (
    .clk_i(clk_i), .srst_i(srst_i), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hready_i(hready), .hwdata_i(hwdata), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .polarity_strap_i(strap),
    .preset_one_select_i(pin[0]), .preset_two_select_i(pin[1]),
    .preset_three_select_i(pin[2]), .preset_four_select_i(pin[3]),
    .preset_five_select_i(pin[4]), .preset_six_select_i(pin[5]),
    .off_request_i(pin[6]), .power_up_request_i(pin[7]),
    .power_down_request_i(pin[8]), .primary_source_select_i(pin[9]),
    .backup_source_select_i(pin[10]), .mute_request_i(pin[11]),
    .fault_reset_request_i(pin[12]), .exciter_analog_only_in_i(exc[0]),
    .exciter_digital_on_in_i(exc[1]), .exciter_digital_off_in_i(exc[2]),
    .exciter_halt_in_i(exc[3]), .rf_on_o(rf_on), .power_level_o(level),
    .mute_o(mute), .audio_backup_o(backup), .fault_clear_o(fclr),
    .at_preset_three_out_o(at_pre[0]), .at_preset_four_out_o(at_pre[1]),
    .at_preset_five_out_o(at_pre[2]), .at_preset_six_out_o(at_pre[3]));

  // Free-running system clock.
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // Counts the fault-clear pulses so repeats of a held command show.
  always @(posedge clk_i) begin
    if (fclr === 1'b1) pulses <= pulses + 1;
  end

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask : check

  task automatic check_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : check_flag

  // Single word transfer; read data is taken at the edge ending data phase.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  // Lets n edges pass, then stops mid-cycle where outputs are settled.
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  // Holds one contact active for n cycles, then leaves time for the effect.
  task automatic hold(input int idx, input int n);
    @(posedge clk_i);
    press[idx] <= 1'b1;
    repeat (n) @(posedge clk_i);
    press[idx] <= 1'b0;
    settle(6);
  endtask : hold

  // Waits a bounded time for the ramp to reach its target.
  task automatic wait_level(input logic [15:0] exp);
    int k;
    k = 0;
    while (level !== exp && k < 500) begin
      @(negedge clk_i);
      k++;
    end
    settle(3);
    check({16'h0, level}, {16'h0, exp});
  endtask : wait_level

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done

  // ************************************************************
  // Sequence
  // ************************************************************
  // Watchdog, far beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    test_done;
  end

  initial begin
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    bus(1'b0, 8'h1C, 32'h0);
    check(rd, 32'h0100_0000);
    // Remote enable must come out of reset switched off.
    bus(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0);
    // Remote control is still disabled: only the mute acts.
    hold(2, QUAL + 2);
    check_flag(rf_on, 1'b0);
    @(posedge clk_i);
    press[11] <= 1'b1;
    settle(QUAL + 5);
    check_flag(mute, 1'b1);
    @(posedge clk_i);
    press[11] <= 1'b0;
    settle(4);
    check_flag(mute, 1'b0);
    // Enable and load distinct odd preset values.
    bus(1'b1, 8'h00, 32'h1);
    for (int n = 0; n < 6; n++) begin
      bus(1'b1, 8'h04 + 8'(4 * n), 32'(2 * n + 3));
    end
    for (int n = 0; n < 6; n++) begin
      hold(n, QUAL + 2);
      wait_level(16'(2 * n + 3));
      check_flag(rf_on, 1'b1);
      check({28'h0, at_pre}, (n >= 2) ? 32'h1 << (n - 2) : 32'h0);
    end
    // Preset four holds the value 9, so this ramps down from 13.
    hold(3, QUAL + 2);
    wait_level(16'h0009);
    check({28'h0, at_pre}, 32'h2);
    // Raise held for about six ramp ticks, then lower for about four.
    @(posedge clk_i);
    press[7] <= 1'b1;
    repeat (QUAL + 3 + RAMP * 6) @(posedge clk_i);
    press[7] <= 1'b0;
    settle(6);
    lvl = level;
    check_flag(lvl > 16'h0009, 1'b1);
    settle(RAMP * 4);
    check({16'h0, level}, {16'h0, lvl});
    check({28'h0, at_pre}, 32'h0);
    @(posedge clk_i);
    press[8] <= 1'b1;
    repeat (QUAL + 3 + RAMP * 4) @(posedge clk_i);
    press[8] <= 1'b0;
    settle(6);
    check_flag(level < lvl, 1'b1);
    lvl = level;
    settle(RAMP * 4);
    check({16'h0, level}, {16'h0, lvl});
    // A pulse too short is dropped; one of exactly the minimum counts.
    hold(6, QUAL / 2);
    check_flag(rf_on, 1'b1);
    hold(6, QUAL);
    check_flag(rf_on, 1'b0);
    hold(10, QUAL + 2);
    check_flag(backup, 1'b1);
    hold(9, QUAL + 2);
    check_flag(backup, 1'b0);
    // A long hold of fault reset must clear exactly once.
    hold(12, QUAL * 3);
    check(32'(pulses), 32'h1);
    // Active-low contacts, then disabled remote ignores a command.
    @(posedge clk_i);
    strap <= 1'b0;
    settle(4);
    hold(10, QUAL + 2);
    check_flag(backup, 1'b1);
    bus(1'b1, 8'h00, 32'h0);
    hold(9, QUAL + 2);
    check_flag(backup, 1'b1);
    test_done;
  end
endmodule : testbench
